// >>> logic/upi_pkg.sv
// package: shared constants and types for the universal pulse input counter
// assumes: 10 MHz clock, scan cycle marked by a one-cycle scan strobe
package upi_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DB_W = 18;
  localparam logic [15:0] DEBOUNCE_RATE_LIMIT = 16'h0019;
  localparam int unsigned FILT_W = 4;
  localparam logic [FILT_W-1:0] FILT_LEN = 4'h4;
  localparam int unsigned BYPASS_SCANS_W = 3;
  localparam logic [BYPASS_SCANS_W-1:0] BYPASS_SCANS = 3'h4;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SCALE_W = 16;
  localparam int unsigned SCALE_FRAC = 8;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned GATE_W = 24;
  localparam logic [GATE_W-1:0] GATE_CYC = 24'h989680;
  localparam int unsigned NCH = 2;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
  typedef enum logic [1:0] {
    RST_NONE = 2'b00,
    RST_HOT = 2'b01,
    RST_WARM = 2'b11,
    RST_COLD = 2'b10
  } restart_e;
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_QUAL = 2'b01,
    PS_HIGH = 2'b11
  } pulse_e;
endpackage : upi_pkg

// >>> logic/upi_cfg_if.sv
// interface: per-channel configuration and control carried into a channel
// assumes: driven by the top from its plain ports
`timescale 1ns/1ps
interface upi_cfg_if;
  logic [15:0] upper_rate_limit;
  logic [15:0] lower_rate_limit;
  logic [upi_pkg::SCALE_W-1:0] count_scale;
  logic [upi_pkg::FREQ_W-1:0] eng_min;
  logic [upi_pkg::FREQ_W-1:0] eng_max;
  logic count_reset;
  logic direction;
  logic track_count_in;
  logic [upi_pkg::CNT_W-1:0] track_value;
  logic keep_value_on_restart;
  modport src (output upper_rate_limit, lower_rate_limit, count_scale, eng_min, eng_max,
    count_reset, direction, track_count_in, track_value, keep_value_on_restart);
  modport dst (input upper_rate_limit, lower_rate_limit, count_scale, eng_min, eng_max,
    count_reset, direction, track_count_in, track_value, keep_value_on_restart);
endinterface : upi_cfg_if

// >>> logic/upi_channel.sv
// channel: debounce, count, frequency and quality for one input
// assumes: pulse input synchronous to i_clk, one-cycle scan strobe
`timescale 1ns/1ps
module upi_channel (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scan,
  input wire logic i_pulse,
  input wire logic i_hw_fail,
  input wire logic i_bypass,
  input wire upi_pkg::restart_e i_restart,
  upi_cfg_if.dst cfg,
  output logic o_input_state,
  output logic [upi_pkg::CNT_W-1:0] o_count,
  output logic [upi_pkg::FREQ_W-1:0] o_freq,
  output logic o_quality_bad
);
  localparam int unsigned DB_W = upi_pkg::DB_W;
  localparam int unsigned CNT_W = upi_pkg::CNT_W;
  localparam int unsigned SCALE_W = upi_pkg::SCALE_W;
  localparam int unsigned SCALE_FRAC = upi_pkg::SCALE_FRAC;
  localparam int unsigned FREQ_W = upi_pkg::FREQ_W;

  // ----------------------------------------------------------------
  // digital filter and debounce
  // ----------------------------------------------------------------
  logic [upi_pkg::FILT_W-1:0] filt_r, filt_nxt;
  logic filt_lvl_r, filt_lvl_nxt;
  logic [upi_pkg::DB_W-1:0] db_r, db_nxt;
  upi_pkg::pulse_e ps_r, ps_nxt;
  logic [upi_pkg::CNT_W-1:0] raw_r, raw_nxt;
  logic [upi_pkg::GATE_W-1:0] gate_r, gate_nxt;
  logic [15:0] edges_r, edges_nxt;
  logic [15:0] rate_r, rate_nxt;
  logic is_r, is_nxt;
  logic [upi_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [upi_pkg::FREQ_W-1:0] frq_r, frq_nxt;
  logic qb_r, qb_nxt;
  logic lvl, debounce_on, valid_pulse;
  logic [upi_pkg::CNT_W+upi_pkg::SCALE_W-1:0] prod;
  logic [31:0] span_e, span_f, num;

  always_comb begin
    debounce_on = cfg.upper_rate_limit <= upi_pkg::DEBOUNCE_RATE_LIMIT;
    filt_nxt = filt_r;
    filt_lvl_nxt = filt_lvl_r;
    if (i_bypass) begin
      filt_lvl_nxt = i_pulse;
      filt_nxt = '0;
    end else if (i_pulse == filt_lvl_r) begin
      filt_nxt = '0;
    end else if (filt_r == upi_pkg::FILT_LEN - 4'h1) begin
      filt_lvl_nxt = i_pulse;
      filt_nxt = '0;
    end else begin
      filt_nxt = filt_r + 4'h1;
    end
    lvl = filt_lvl_r;
    valid_pulse = 1'b0;
    db_nxt = db_r;
    ps_nxt = ps_r;
    case (ps_r)
      upi_pkg::PS_IDLE: begin
        db_nxt = '0;
        if (lvl) begin
          if (debounce_on) begin
            ps_nxt = upi_pkg::PS_QUAL;
          end else begin
            ps_nxt = upi_pkg::PS_HIGH;
            valid_pulse = 1'b1;
          end
        end
      end
      upi_pkg::PS_QUAL: begin
        if (!lvl) begin
          ps_nxt = upi_pkg::PS_IDLE;
        end else if (db_r == DB_W'(upi_pkg::DEBOUNCE_CYC - 1)) begin
          ps_nxt = upi_pkg::PS_HIGH;
          valid_pulse = 1'b1;
        end else begin
          db_nxt = db_r + 18'h00001;
        end
      end
      upi_pkg::PS_HIGH: begin
        if (!lvl) begin
          ps_nxt = upi_pkg::PS_IDLE;
        end
      end
      default: ps_nxt = upi_pkg::PS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // count, rate measure and scan outputs
  // ----------------------------------------------------------------
  always_comb begin
    raw_nxt = raw_r;
    if (i_restart == upi_pkg::RST_COLD ||
        (i_restart == upi_pkg::RST_WARM && !cfg.keep_value_on_restart)) begin
      raw_nxt = upi_pkg::CNT_RESET;
    end else if (i_restart != upi_pkg::RST_NONE) begin
      raw_nxt = raw_r;
    end else if (cfg.count_reset) begin
      raw_nxt = upi_pkg::CNT_RESET;
    end else if (valid_pulse) begin
      raw_nxt = cfg.direction ? raw_r + 32'h00000001 : raw_r - 32'h00000001;
    end
    gate_nxt = gate_r + 24'h000001;
    edges_nxt = valid_pulse ? edges_r + 16'h0001 : edges_r;
    rate_nxt = rate_r;
    if (gate_r == upi_pkg::GATE_CYC - 24'h000001) begin
      gate_nxt = '0;
      rate_nxt = edges_nxt;
      edges_nxt = '0;
    end
    prod = (CNT_W + SCALE_W)'($signed(raw_r) * $signed({1'b0, cfg.count_scale}));
    span_e = {16'h0000, cfg.eng_max - cfg.eng_min};
    span_f = {16'h0000, cfg.upper_rate_limit - cfg.lower_rate_limit};
    num = 32'h00000000;
    if (rate_r > cfg.lower_rate_limit && span_f != 32'h00000000) begin
      num = ({16'h0000, rate_r - cfg.lower_rate_limit} * span_e) / span_f;
    end
    if (rate_r >= cfg.upper_rate_limit) begin
      num = span_e;
    end
    is_nxt = is_r;
    cnt_nxt = cnt_r;
    frq_nxt = frq_r;
    qb_nxt = qb_r;
    if (i_scan) begin
      is_nxt = i_pulse;
      cnt_nxt = cfg.track_count_in ? cfg.track_value
                : prod[SCALE_FRAC +: CNT_W];
      frq_nxt = cfg.eng_min + num[FREQ_W-1:0];
      qb_nxt = i_hw_fail;
    end
    if (cfg.count_reset && !cfg.track_count_in) begin
      cnt_nxt = upi_pkg::CNT_RESET;
    end
    // a clearing restart zeroes the output at once, not at the next scan
    if ((i_restart == upi_pkg::RST_COLD ||
        (i_restart == upi_pkg::RST_WARM && !cfg.keep_value_on_restart)) &&
        !cfg.track_count_in) begin
      cnt_nxt = upi_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_r <= '0;
      filt_lvl_r <= 1'b0;
      db_r <= '0;
      ps_r <= upi_pkg::PS_IDLE;
      raw_r <= upi_pkg::CNT_RESET;
      gate_r <= '0;
      edges_r <= '0;
      rate_r <= '0;
      is_r <= 1'b0;
      cnt_r <= upi_pkg::CNT_RESET;
      frq_r <= '0;
      qb_r <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      filt_lvl_r <= filt_lvl_nxt;
      db_r <= db_nxt;
      ps_r <= ps_nxt;
      raw_r <= raw_nxt;
      gate_r <= gate_nxt;
      edges_r <= edges_nxt;
      rate_r <= rate_nxt;
      is_r <= is_nxt;
      cnt_r <= cnt_nxt;
      frq_r <= frq_nxt;
      qb_r <= qb_nxt;
    end
  end

  assign o_input_state = is_r;
  assign o_count = cnt_r;
  assign o_freq = frq_r;
  assign o_quality_bad = qb_r;
endmodule : upi_channel

// >>> logic/universal_pulse_input.sv
// top: two universal pulse input channels with restart handling
// assumes: all inputs synchronous to i_clk; i_scan pulses once per controller scan
`timescale 1ns/1ps
// How it works
// - count output is pulses since reset times the scale factor, fixed point.
// - input state sampled at each scan start, 1 for high, 0 for low.
// - debounce on when the upper rate limit is 25 or less.
// - with debounce, a pulse counts only after 20 ms continuously high.
// - frequency output linear between rate limits onto the engineering range.
// - reset input forces the count output to zero, except while tracking is on.
// - direction low counts down into negatives, else counts up.
// - while tracking, count output follows the external tracking value.
// - quality bad goes high when converter hardware has failed.
// - keep-on-restart holds the count across hot or warm restart.
// - without keep-on-restart, warm or cold restart clears the count.
// - any restart temporarily bypasses the digital input filter.
// - two independent channels, each with its own outputs.
module universal_pulse_input (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scan,
  input wire upi_pkg::restart_e i_restart,
  input wire logic [upi_pkg::NCH-1:0] i_pulse,
  input wire logic [upi_pkg::NCH-1:0] i_hw_fail,
  input wire logic [upi_pkg::NCH-1:0] i_count_reset,
  input wire logic [upi_pkg::NCH-1:0] i_direction,
  input wire logic [upi_pkg::NCH-1:0] i_track_count_in,
  input wire logic [upi_pkg::NCH*upi_pkg::CNT_W-1:0] i_track_value,
  input wire logic [upi_pkg::NCH-1:0] i_keep_value_on_restart,
  input wire logic [upi_pkg::NCH*16-1:0] i_upper_rate_limit,
  input wire logic [upi_pkg::NCH*16-1:0] i_lower_rate_limit,
  input wire logic [upi_pkg::NCH*upi_pkg::SCALE_W-1:0] i_count_scale,
  input wire logic [upi_pkg::NCH*upi_pkg::FREQ_W-1:0] i_eng_min,
  input wire logic [upi_pkg::NCH*upi_pkg::FREQ_W-1:0] i_eng_max,
  output logic [upi_pkg::NCH-1:0] o_input_state_out,
  output logic [upi_pkg::NCH*upi_pkg::CNT_W-1:0] o_scaled_count_out,
  output logic [upi_pkg::NCH*upi_pkg::FREQ_W-1:0] o_scaled_freq_out,
  output logic [upi_pkg::NCH-1:0] o_quality_bad_out
);
  // ----------------------------------------------------------------
  // restart filter bypass window, counted in scans
  // ----------------------------------------------------------------
  logic [upi_pkg::BYPASS_SCANS_W-1:0] byp_r, byp_nxt;
  always_comb begin
    byp_nxt = byp_r;
    if (i_restart != upi_pkg::RST_NONE) begin
      byp_nxt = upi_pkg::BYPASS_SCANS;
    end else if (i_scan && byp_r != '0) begin
      byp_nxt = byp_r - 3'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      byp_r <= upi_pkg::BYPASS_SCANS;
    end else begin
      byp_r <= byp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < upi_pkg::NCH; c++) begin : g_ch
    upi_cfg_if cfg ();
    assign cfg.upper_rate_limit = i_upper_rate_limit[c*16 +: 16];
    assign cfg.lower_rate_limit = i_lower_rate_limit[c*16 +: 16];
    assign cfg.count_scale = i_count_scale[c*upi_pkg::SCALE_W +: upi_pkg::SCALE_W];
    assign cfg.eng_min = i_eng_min[c*upi_pkg::FREQ_W +: upi_pkg::FREQ_W];
    assign cfg.eng_max = i_eng_max[c*upi_pkg::FREQ_W +: upi_pkg::FREQ_W];
    assign cfg.count_reset = i_count_reset[c];
    assign cfg.direction = i_direction[c];
    assign cfg.track_count_in = i_track_count_in[c];
    assign cfg.track_value = i_track_value[c*upi_pkg::CNT_W +: upi_pkg::CNT_W];
    assign cfg.keep_value_on_restart = i_keep_value_on_restart[c];
    upi_channel u_ch (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_scan(i_scan),
      .i_pulse(i_pulse[c]),
      .i_hw_fail(i_hw_fail[c]),
      .i_bypass(byp_r != '0),
      .i_restart(i_restart),
      .cfg(cfg),
      .o_input_state(o_input_state_out[c]),
      .o_count(o_scaled_count_out[c*upi_pkg::CNT_W +: upi_pkg::CNT_W]),
      .o_freq(o_scaled_freq_out[c*upi_pkg::FREQ_W +: upi_pkg::FREQ_W]),
      .o_quality_bad(o_quality_bad_out[c])
    );
  end
endmodule : universal_pulse_input

// >>> test/upi_pulse_src.sv
// partner: field contact or pulse transmitter on one input
// assumes: an open contact reads low between pulses
`timescale 1ns/1ps
module upi_pulse_src (
  input wire logic i_clk,
  output logic o_pulse
);
  initial o_pulse = 1'b0;
  // n pulses, each high and then low for hi cycles
  task automatic burst(input int n, input int hi);
    repeat (n) begin
      @(posedge i_clk);
      #5 o_pulse = 1'b1;
      repeat (hi) @(posedge i_clk);
      #5 o_pulse = 1'b0;
      repeat (hi) @(posedge i_clk);
    end
  endtask : burst
  task automatic level(input logic v);
    @(posedge i_clk);
    #5 o_pulse = v;
  endtask : level
endmodule : upi_pulse_src

// >>> test/upi_props.sv
// checker: port timing of the pulse input counter
// assumes: bound to the top, one clock, async active-low reset
`timescale 1ns/1ps
module upi_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scan,
  input wire upi_pkg::restart_e i_restart,
  input wire logic [1:0] i_hw_fail,
  input wire logic [1:0] i_count_reset,
  input wire logic [1:0] i_track_count_in,
  input wire logic [63:0] i_track_value,
  input wire logic [1:0] o_input_state_out,
  input wire logic [63:0] o_scaled_count_out,
  input wire logic [1:0] o_quality_bad_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic idle;
  assign idle = !i_scan && i_restart == upi_pkg::RST_NONE && i_count_reset == 2'h0;
  sequence s_trk0;
    i_scan && i_track_count_in[0];
  endsequence
  a_track_follow: assert property (s_trk0 |=>
    o_scaled_count_out[31:0] == $past(i_track_value[31:0])) else $error("track ch0");
  a_track_chan1: assert property (i_scan && i_track_count_in[1] |=>
    o_scaled_count_out[63:32] == $past(i_track_value[63:32])) else $error("track ch1");
  a_quality_scan: assert property (i_scan |=>
    o_quality_bad_out == $past(i_hw_fail)) else $error("quality");
  a_status_hold: assert property (idle |=>
    $stable({o_input_state_out, o_quality_bad_out})) else $error("status moved");
  a_count_hold: assert property (idle && $past(i_restart) == upi_pkg::RST_NONE |=>
    $stable(o_scaled_count_out)) else $error("count moved");
  a_reset_zero: assert property (i_count_reset[0] && !i_track_count_in[0]
    && i_restart == upi_pkg::RST_NONE |=> o_scaled_count_out[31:0] == 32'h0)
    else $error("reset");
  a_cold_clear: assert property (i_restart == upi_pkg::RST_COLD && !i_scan
    |-> ##[1:2] o_scaled_count_out == 64'h0) else $error("cold");
  a_hot_keep: assert property (i_restart == upi_pkg::RST_HOT && !i_scan
    |=> $stable(o_scaled_count_out)) else $error("hot");
endmodule : upi_props
bind universal_pulse_input upi_props u_props (.i_clk, .i_rst_b, .i_scan, .i_restart,
  .i_hw_fail, .i_count_reset, .i_track_count_in, .i_track_value, .o_input_state_out,
  .o_scaled_count_out, .o_quality_bad_out);

// >>> test/universal_pulse_input_tb.sv
// testbench: two counter channels against an integer model
// assumes: partner sources drive the field inputs
`timescale 1ns/1ps
module universal_pulse_input_tb;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_scan = 1'b0;
  upi_pkg::restart_e i_restart = upi_pkg::RST_NONE;
  logic [1:0] hw_fail = 2'h0, cnt_rst = 2'h0, dir = 2'h1, trk = 2'h0, keep = 2'h1;
  logic [63:0] trk_val = 64'h0;
  logic [31:0] upper = 32'h00640064;
  wire logic [1:0] pulse, st, qb;
  wire logic [63:0] cnt;
  int err_total = 0, n_checks = 0, n0, n1;
  int m [2] = '{0, 0};
  always #50 i_clk = ~i_clk;
  upi_pulse_src src0 (.i_clk(i_clk), .o_pulse(pulse[0]));
  upi_pulse_src src1 (.i_clk(i_clk), .o_pulse(pulse[1]));
  universal_pulse_input DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scan(i_scan),
    .i_restart(i_restart), .i_pulse(pulse), .i_hw_fail(hw_fail), .i_count_reset(cnt_rst),
    .i_direction(dir), .i_track_count_in(trk), .i_track_value(trk_val),
    .i_keep_value_on_restart(keep), .i_upper_rate_limit(upper),
    .i_lower_rate_limit(32'h00010001), .i_count_scale(32'h02000100), .i_eng_min(32'h0),
    .i_eng_max(32'h03E803E8), .o_input_state_out(st), .o_scaled_count_out(cnt),
    .o_scaled_freq_out(), .o_quality_bad_out(qb));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic scan();
    @(posedge i_clk);
    #5 i_scan = 1'b1;
    @(posedge i_clk);
    #5 i_scan = 1'b0;
  endtask : scan
  // channel 1 runs at scale 2.0
  task automatic counts();
    chk("count0", m[0], cnt[31:0]);
    chk("count1", m[1] * 2, cnt[63:32]);
  endtask : counts
  task automatic restart(input upi_pkg::restart_e r);
    @(posedge i_clk);
    #5 i_restart = r;
    @(posedge i_clk);
    #5 i_restart = upi_pkg::RST_NONE;
  endtask : restart
  // channel 0 counts up, channel 1 down
  task automatic bursts(input int a, input int b);
    fork
      src0.burst(a, 10);
      src1.burst(b, 10);
    join
    m[0] += a;
    m[1] -= b;
    repeat (8) @(posedge i_clk);
    scan();
    counts();
  endtask : bursts
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #4000000;
    err_total++;
    report_and_stop();
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    void'($urandom(14));
    dir = 2'h1;
    repeat (12) @(posedge i_clk);
    #5 i_rst_b = 1'b1;
    scan();
    counts();
    n0 = 1 + $urandom % 8;
    n1 = 1 + $urandom % 8;
    bursts(n0, n1);
    src0.level(1'b1);
    repeat (8) @(posedge i_clk);
    scan();
    m[0]++;
    chk("state", 32'h1, {30'h0, st});
    counts();
    src0.level(1'b0);
    upper[15:0] = 16'h0019;
    src0.burst(1, 100);
    scan();
    counts();
    upper[15:0] = 16'h0064;
    hw_fail = 2'h2;
    scan();
    chk("quality", 32'h2, {30'h0, qb});
    hw_fail = 2'h0;
    trk_val = {$urandom, $urandom};
    trk = 2'h3;
    scan();
    chk("track0", trk_val[31:0], cnt[31:0]);
    chk("track1", trk_val[63:32], cnt[63:32]);
    chk("quality", 32'h0, {30'h0, qb});
    trk = 2'h0;
    scan();
    counts();
    dir = 2'h3;
    src1.burst(2, 10);
    m[1] += 2;
    repeat (8) @(posedge i_clk);
    scan();
    counts();
    dir = 2'h1;
    cnt_rst = 2'h3;
    scan();
    cnt_rst = 2'h0;
    m = '{0, 0};
    scan();
    counts();
    bursts(n1, n0);
    restart(upi_pkg::RST_HOT);
    scan();
    counts();
    restart(upi_pkg::RST_WARM);
    m[1] = 0;
    scan();
    counts();
    restart(upi_pkg::RST_COLD);
    m[0] = 0;
    scan();
    counts();
    bursts(3, 2);
    report_and_stop();
  end
endmodule : universal_pulse_input_tb
